// >>> msc_pkg.sv
// shared constants and types for the module sideband control ends
package msc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 600;
  localparam int LINK_QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QTR_LAST = 4'(LINK_QTR_CYC - 1);
  localparam logic [15:0] RST_MIN_CYC_DEF = 16'h0014;
  localparam logic [23:0] INIT_CYC_DEF = 24'h000064;

  // 2-wire addressing and frame layout
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] SLOT_ADDR_ACK = 5'h08;
  localparam logic [4:0] SLOT_LAST = 5'h11;

  // synchroniser lanes on the module end
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_RST = 3;
  localparam int PIN_LPM = 4;
  localparam int DEV_PINS = 5;

  // module status byte
  localparam int ST_INIT_PEND = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_LOWPWR = 3;

  // host register map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam int CMD_GO = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam int STAT_PRESENT = 16;
  localparam int STAT_TRUSTED = 17;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ALERT = 1;
  localparam int IRQ_PRES = 2;
  localparam int IRQ_W = 3;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_LPM = 2;
  localparam int CTRL_AUTO = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {IDX_CMD, IDX_STAT, IDX_ISTAT, IDX_MASK, IDX_CTRL, IDX_NONE} msc_idx_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK1, S_WDATA, S_ACK2, S_RDATA, S_RACK} msc_slv_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} msc_mst_t;
endpackage

// >>> msc_if.sv
// sideband pins between host board and module, with board pull-ups
`timescale 1ns/100ps
interface msc_if;
  logic sclOeHost;
  logic sdaOeHost;
  logic sdaOeDev;
  logic alertOeDev;
  logic presentOeDev;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic scl;
  logic sda;
  logic fault_alert_n;
  logic module_present_n;

  // open-drain lines: low while any end pulls, else pulled high
  assign scl = ~sclOeHost;
  assign sda = ~(sdaOeHost | sdaOeDev);
  assign fault_alert_n = ~alertOeDev;
  assign module_present_n = ~presentOeDev;

  modport dev (
    input scl, sda, module_select_n, module_reset_n, low_power_select,
    output sdaOeDev, alertOeDev, presentOeDev
  );
  modport host (
    input sda, fault_alert_n, module_present_n,
    output sclOeHost, sdaOeHost, module_select_n, module_reset_n, low_power_select
  );
endinterface

// >>> msc_device.sv
// module end: select gating, reset filter, init handshake, alert and power pins
//
// Function
// R1: answer bus only while select is low
// R2: host gives each module its own select
// R3: long reset pulse restores every default
// R4: host distrusts status until reset completes; here trust returns at the next alert fall, even one from a fault
// R5: completion posts alert and clears pending flag
// R6: power-up posts completion alert without reset
// R7: low-power pin caps module power
// R8: presence line pulled low by module
// R9: alert pulled low on fault or critical status; here only faultEvent or init completion pulls it
// R10: host reads status to find alert cause
// R11: alert only pulled low, board pull-up
// R12: minimum reset length is a cycle parameter
// R13: pending flag set until completion alert
`timescale 1ns/100ps
module msc_device
  import msc_pkg::*;
#(
  parameter logic [15:0] RST_MIN_CYC = RST_MIN_CYC_DEF,
  parameter logic [23:0] INIT_CYC = INIT_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins toward the host board
  msc_if.dev link,
  // module-side events and settings
  input wire logic faultEvent,
  output logic lowPowerMode,
  output logic [7:0] settingByte,
  output logic initPending,
  output logic inReset
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [DEV_PINS-1:0] pinRaw;
  logic [DEV_PINS-1:0] meta_r;
  logic [DEV_PINS-1:0] sync_r;
  logic sclD_r;
  logic sdaD_r;

  assign pinRaw = {link.low_power_select, link.module_reset_n,
                   link.module_select_n, link.sda, link.scl};

  // every host pin is asynchronous to the module clock
  genvar gi;
  generate
    for (gi = 0; gi < DEV_PINS; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= pinRaw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  // delayed copies for edge finding, taken after the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sync_r[PIN_SCL];
      sdaD_r <= sync_r[PIN_SDA];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions
  logic sclS, sdaS, sclRise, sclFall, startCond, stopCond, selected;

  assign sclS = sync_r[PIN_SCL];
  assign sdaS = sync_r[PIN_SDA];
  assign sclRise = sclS & ~sclD_r;
  assign sclFall = ~sclS & sclD_r;
  assign startCond = sclS & sclD_r & ~sdaS & sdaD_r;
  assign stopCond = sclS & sclD_r & sdaS & ~sdaD_r;
  assign selected = ~sync_r[PIN_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse filter and initialisation timer
  logic [15:0] rstCnt_r;
  logic [23:0] initCnt_r;
  logic initPend_r, resetHeld, wipe, initFinish;

  // short glitches restart the count and never reach the threshold
  always_ff @(posedge clk) begin
    if (!rst_b || sync_r[PIN_RST]) begin
      rstCnt_r <= 16'h0000;
    end else if (rstCnt_r != RST_MIN_CYC) begin
      rstCnt_r <= rstCnt_r + 16'h0001; // [R12]
    end
  end

  assign resetHeld = (rstCnt_r == RST_MIN_CYC); // [R3] [R12]
  assign wipe = ~rst_b | resetHeld;
  assign initFinish = initPend_r & (initCnt_r == INIT_CYC - 24'h000001);

  // pending from power-up or any held reset until the timer runs out
  always_ff @(posedge clk) begin
    if (wipe) begin
      initPend_r <= 1'b1; // [R13] [R6]
      initCnt_r <= 24'h000000;
    end else if (initFinish) begin
      initPend_r <= 1'b0; // [R5] [R13]
    end else if (initPend_r) begin
      initCnt_r <= initCnt_r + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky alert sources
  logic doneFlag_r, faultFlag_r, doneNxt, faultNxt, readLoad, lowPwr_r;
  logic [7:0] statusByte;

  // a status read clears both flags; a new event in that cycle wins
  assign doneNxt = ~wipe & (initFinish | (doneFlag_r & ~readLoad)); // [R5] [R6]
  assign faultNxt = ~wipe & (faultEvent | (faultFlag_r & ~readLoad)); // [R9]

  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_INIT_PEND] = initPend_r;
    statusByte[ST_DONE] = doneFlag_r;
    statusByte[ST_FAULT] = faultFlag_r;
    statusByte[ST_LOWPWR] = lowPwr_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 2-wire slave: address, one write byte to settings, one status read
  msc_slv_t st_r, stNxt;
  logic [3:0] bitCnt_r, bitNxt;
  logic [7:0] shift_r, shiftNxt, tx_r, txNxt, ctrl_r, ctrlNxt;
  logic rw_r, rwNxt, sdaOe_r, oeNxt;

  // drive changes only on a falling clock so data is stable while high
  always_comb begin
    stNxt = st_r;
    bitNxt = bitCnt_r;
    shiftNxt = shift_r;
    txNxt = tx_r;
    ctrlNxt = ctrl_r;
    rwNxt = rw_r;
    oeNxt = sdaOe_r;
    readLoad = 1'b0;
    if (wipe || !selected || stopCond) begin
      stNxt = S_IDLE; // [R1]
      oeNxt = 1'b0;
      if (wipe) begin
        ctrlNxt = 8'h00; // [R3]
      end
    end else if (startCond) begin
      stNxt = S_ADDR;
      bitNxt = 4'h0;
      oeNxt = 1'b0;
    end else begin
      case (st_r)
        S_ADDR, S_WDATA: begin
          if (sclRise) begin
            shiftNxt = {shift_r[6:0], sdaS};
            bitNxt = bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == BYTE_BITS) begin
            if (st_r == S_WDATA) begin
              ctrlNxt = shift_r;
              stNxt = S_ACK2;
              oeNxt = 1'b1;
            end else if (shift_r[7:1] == DEV_ADDR) begin
              rwNxt = shift_r[0];
              stNxt = S_ACK1;
              oeNxt = 1'b1;
            end else begin
              stNxt = S_IDLE;
            end
          end
        end
        S_ACK1: begin
          if (sclFall) begin
            bitNxt = 4'h0;
            if (rw_r) begin
              stNxt = S_RDATA;
              txNxt = statusByte;
              oeNxt = ~statusByte[7];
              readLoad = 1'b1; // [R10]
            end else begin
              stNxt = S_WDATA;
              oeNxt = 1'b0;
            end
          end
        end
        S_RDATA: begin
          if (sclFall) begin
            if (bitCnt_r == BYTE_BITS - 4'h1) begin
              stNxt = S_RACK;
              oeNxt = 1'b0;
            end else begin
              txNxt = {tx_r[6:0], 1'b0};
              oeNxt = ~tx_r[6];
              bitNxt = bitCnt_r + 4'h1;
            end
          end
        end
        S_ACK2, S_RACK: begin
          if (sclFall) begin
            stNxt = S_IDLE;
            oeNxt = 1'b0;
          end
        end
        default: begin
          stNxt = S_IDLE;
          oeNxt = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and pin registers
  logic alertOe_r, presentOe_r, inReset_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ctrl_r <= 8'h00;
      rw_r <= 1'b0;
      sdaOe_r <= 1'b0;
      doneFlag_r <= 1'b0;
      faultFlag_r <= 1'b0;
      alertOe_r <= 1'b0;
      lowPwr_r <= 1'b1;
      presentOe_r <= 1'b1;
      inReset_r <= 1'b1;
    end else begin
      st_r <= stNxt;
      bitCnt_r <= bitNxt;
      shift_r <= shiftNxt;
      tx_r <= txNxt;
      ctrl_r <= ctrlNxt;
      rw_r <= rwNxt;
      sdaOe_r <= oeNxt;
      doneFlag_r <= doneNxt;
      faultFlag_r <= faultNxt;
      alertOe_r <= doneNxt | faultNxt; // [R5] [R9] [R11]
      lowPwr_r <= sync_r[PIN_LPM]; // [R7]
      presentOe_r <= 1'b1; // [R8]
      inReset_r <= resetHeld; // [R3]
    end
  end

  // pins are pull-low enables only; the line is never driven high
  assign link.sdaOeDev = sdaOe_r;
  assign link.alertOeDev = alertOe_r; // [R11]
  assign link.presentOeDev = presentOe_r;
  assign lowPowerMode = lowPwr_r;
  assign settingByte = ctrl_r;
  assign initPending = initPend_r;
  assign inReset = inReset_r;

endmodule

// >>> msc_host.sv
// host end: AXI4-Lite registers driving select, reset, low power and a 2-wire master
`timescale 1ns/100ps
module msc_host
  import msc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins toward the module
  msc_if.host link,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt
  output logic irq
);

  function automatic msc_idx_t regIdx(input logic [7:0] a);
    case (a)
      OFS_CMD: regIdx = IDX_CMD;
      OFS_STAT: regIdx = IDX_STAT;
      OFS_IRQ_STAT: regIdx = IDX_ISTAT;
      OFS_IRQ_MASK: regIdx = IDX_MASK;
      OFS_CTRL: regIdx = IDX_CTRL;
      default: regIdx = IDX_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: sda, alert, presence

  logic [2:0] pinRaw;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic alertD_r;
  logic presD_r;
  assign pinRaw = {link.module_present_n, link.fault_alert_n, link.sda};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= pinRaw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic sdaS;
  logic alertLow;
  logic present;
  logic alertFall;
  logic presChg;
  assign sdaS = sync_r[0];
  assign alertLow = ~sync_r[1];
  assign present = ~sync_r[2]; // [R8]
  assign alertFall = alertLow & ~alertD_r;
  assign presChg = present ^ presD_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; a write takes both channels in either order

  logic awReady_r, wReady_r, bValid_r, arReady_r, rValid_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r, rData_r, rdWord, wMask, wrVal;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r, rResp_r;
  logic wrFire;
  msc_idx_t wrIdx, rdIdx;
  assign wrFire = ~awReady_r & ~wReady_r & ~bValid_r;
  assign wrIdx = regIdx(awAddr_r);
  assign rdIdx = regIdx(araddr);
  assign wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  assign wrVal = wData_r & wMask;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      arReady_r <= 1'b1;
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awReady_r) begin
        awAddr_r <= awaddr;
        awReady_r <= 1'b0;
      end
      if (wvalid && wReady_r) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wReady_r <= 1'b0;
      end
      if (wrFire) begin
        bValid_r <= 1'b1;
        bResp_r <= (wrIdx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bValid_r && bready) begin
        bValid_r <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r <= 1'b1;
      end
      if (arvalid && arReady_r) begin
        arReady_r <= 1'b0;
        rValid_r <= 1'b1;
        rData_r <= rdWord;
        rResp_r <= (rdIdx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rValid_r && rready) begin
        rValid_r <= 1'b0;
        arReady_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, interrupt and reset-tracking registers

  msc_mst_t st_r, stNxt;
  logic [3:0] ctrl_r;
  logic [IRQ_W-1:0] irqStat_r, irqMask_r, irqNxt, irqEv;
  logic [7:0] txData_r, rxData_r;
  logic rdOp_r, nack_r, rstTrack_r, irq_r, doneEv, goNow, goRd;
  logic [31:0] statWord;

  // write-one-to-clear; an event in the same cycle keeps its bit set
  assign irqEv = {presChg, alertFall, doneEv}; // [R10]
  assign irqNxt = (irqStat_r & ~((wrFire && wrIdx == IDX_ISTAT) ? wrVal[IRQ_W-1:0] : '0)) | irqEv;
  assign goRd = (wrFire && wrIdx == IDX_CMD) ? wrVal[CMD_READ] : 1'b1;
  // auto read of status after an alert; a busy engine refuses new commands
  assign goNow = (st_r == M_IDLE) & ((wrFire & (wrIdx == IDX_CMD) & wrVal[CMD_GO])
                 | (ctrl_r[CTRL_AUTO] & ctrl_r[CTRL_SEL] & alertLow)); // [R10]

  always_comb begin
    statWord = 32'h00000000;
    statWord[STAT_BUSY] = (st_r != M_IDLE);
    statWord[STAT_NACK] = nack_r;
    statWord[STAT_RDATA_LSB +: 8] = rxData_r;
    statWord[STAT_PRESENT] = present;
    statWord[STAT_TRUSTED] = ~rstTrack_r; // [R4]
    case (rdIdx)
      IDX_CMD: rdWord = {16'h0000, txData_r, 8'h00};
      IDX_STAT: rdWord = statWord;
      IDX_ISTAT: rdWord = {29'h00000000, irqStat_r};
      IDX_MASK: rdWord = {29'h00000000, irqMask_r};
      IDX_CTRL: rdWord = {28'h0000000, ctrl_r};
      default: rdWord = 32'h00000000;
    endcase
  end

  logic selN_r, rstN_r, lpm_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET;
      irqStat_r <= '0;
      irqMask_r <= '0;
      irq_r <= 1'b0;
      rstTrack_r <= 1'b1;
      alertD_r <= 1'b0;
      presD_r <= 1'b0;
      selN_r <= 1'b1;
      rstN_r <= 1'b1;
      lpm_r <= 1'b1;
    end else begin
      if (wrFire && wrIdx == IDX_CTRL) ctrl_r <= wrVal[3:0];
      if (wrFire && wrIdx == IDX_MASK) irqMask_r <= wrVal[IRQ_W-1:0];
      irqStat_r <= irqNxt;
      irq_r <= |(irqNxt & irqMask_r);
      // status stays untrusted from reset or insertion until the alert line next falls, whether from completion or a fault
      if (ctrl_r[CTRL_RST] || (presChg && present)) rstTrack_r <= 1'b1; // [R4]
      else if (alertFall) rstTrack_r <= 1'b0; // [R4]
      alertD_r <= alertLow;
      presD_r <= present;
      selN_r <= ~ctrl_r[CTRL_SEL]; // [R2]
      rstN_r <= ~ctrl_r[CTRL_RST];
      lpm_r <= ctrl_r[CTRL_LPM];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 2-wire master: start, 18 bit slots, stop; four quarters per slot

  logic [3:0] q_r;
  logic [1:0] ph_r;
  logic [4:0] slot_r;
  logic [17:0] frame;
  logic tick, lastPh, sampleNow, bitOe, sclOeC, sdaOeC, sclOe_r, sdaOe_r;
  assign frame = {DEV_ADDR, rdOp_r, 1'b1, rdOp_r ? 8'hff : txData_r, 1'b1};
  assign bitOe = ~frame[SLOT_LAST - slot_r];
  assign tick = (q_r == QTR_LAST);
  assign lastPh = tick & (ph_r == 2'h3);
  assign sampleNow = (st_r == M_BITS) & lastPh;
  assign doneEv = (st_r == M_STOP) & lastPh;

  // clock edge and data change never share a cycle, so no false start or stop
  always_comb begin
    stNxt = st_r;
    sclOeC = 1'b0;
    sdaOeC = 1'b0;
    case (st_r)
      M_IDLE: if (goNow) stNxt = M_START;
      M_START: begin
        sclOeC = (ph_r >= 2'h2);
        sdaOeC = (ph_r >= 2'h1);
        if (lastPh) stNxt = M_BITS;
      end
      M_BITS: begin
        sclOeC = (ph_r < 2'h2);
        sdaOeC = (ph_r == 2'h0) ? sdaOe_r : bitOe;
        if (lastPh && slot_r == SLOT_LAST) stNxt = M_STOP;
      end
      M_STOP: begin
        sclOeC = (ph_r < 2'h2);
        sdaOeC = (ph_r == 2'h0) ? sdaOe_r : (ph_r != 2'h3);
        if (lastPh) stNxt = M_IDLE;
      end
      default: stNxt = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= M_IDLE;
      q_r <= 4'h0;
      ph_r <= 2'h0;
      slot_r <= 5'h00;
      rdOp_r <= 1'b0;
      txData_r <= 8'h00;
      rxData_r <= 8'h00;
      nack_r <= 1'b0;
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else begin
      st_r <= stNxt;
      sclOe_r <= sclOeC;
      sdaOe_r <= sdaOeC;
      q_r <= (tick || st_r == M_IDLE) ? 4'h0 : q_r + 4'h1;
      if (st_r == M_IDLE) ph_r <= 2'h0;
      else if (tick) ph_r <= ph_r + 2'h1;
      if (goNow) begin
        rdOp_r <= goRd;
        if (!goRd) txData_r <= wrVal[CMD_DATA_LSB +: 8];
        nack_r <= 1'b0;
        slot_r <= 5'h00;
      end
      if (sampleNow) begin
        slot_r <= slot_r + 5'h01;
        if ((slot_r == SLOT_ADDR_ACK || (slot_r == SLOT_LAST && !rdOp_r)) && sdaS) nack_r <= 1'b1;
        if (rdOp_r && slot_r > SLOT_ADDR_ACK && slot_r < SLOT_LAST) rxData_r <= {rxData_r[6:0], sdaS};
      end
    end
  end

  assign link.sclOeHost = sclOe_r;
  assign link.sdaOeHost = sdaOe_r;
  assign link.module_select_n = selN_r;
  assign link.module_reset_n = rstN_r;
  assign link.low_power_select = lpm_r;
  assign awready = awReady_r;
  assign wready = wReady_r;
  assign bvalid = bValid_r;
  assign bresp = bResp_r;
  assign arready = arReady_r;
  assign rvalid = rValid_r;
  assign rdata = rData_r;
  assign rresp = rResp_r;
  assign irq = irq_r;

endmodule

// >>> msc_properties.sv
// concurrent checks on the sideband pins between host and module
`timescale 1ns/100ps
module msc_properties #(
  parameter int RST_MIN_CYC = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  input wire logic sdaOeDev,
  input wire logic alertOeDev,
  input wire logic module_present_n,
  // module user side
  input wire logic faultEvent,
  input wire logic lowPowerMode
);
  logic [7:0] lowCnt_r;
  //////////////////////////////////////////////////////////////////////////////
  // low cycles of the reset pin; saturates so a long hold never wraps to short
  always_ff @(posedge clk) begin
    if (!rst_b || module_reset_n) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hff) lowCnt_r <= lowCnt_r + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // margins of a few cycles cover the two-stage pin synchroniser
  chk_present_low: assert property (!module_present_n)
    else $error("presence line not low");
  chk_select_gate: assert property (module_select_n [*4] |-> !sdaOeDev)
    else $error("data pulled while deselected");
  chk_reset_clears: assert property (int'(lowCnt_r) == RST_MIN_CYC + 6 |-> !alertOeDev)
    else $error("long reset left alert set");
  chk_short_ignored: assert property ($rose(module_reset_n) && int'(lowCnt_r) < RST_MIN_CYC
    && alertOeDev |-> alertOeDev [*6])
    else $error("short reset pulse acted");
  chk_reset_done: assert property ($rose(module_reset_n) && int'(lowCnt_r) >= RST_MIN_CYC + 6
    |-> !alertOeDev [*6] ##[1:20] alertOeDev)
    else $error("completion alert missing");
  chk_powerup_done: assert property ($rose(rst_b) |-> !alertOeDev [*6] ##[1:20] alertOeDev)
    else $error("power-up alert missing");
  chk_fault_alert: assert property (faultEvent |-> ##[1:2] alertOeDev)
    else $error("fault not alerted");
  chk_low_power: assert property ($changed(low_power_select)
    |-> ##[1:4] (lowPowerMode == low_power_select))
    else $error("low power pin not followed");
  cover property ($rose(module_reset_n) && int'(lowCnt_r) < RST_MIN_CYC);
  cover property (faultEvent);
  cover property (!module_select_n && sdaOeDev);
endmodule

// >>> tb_top.sv
// self-checking bench: host and module ends joined over the pin interface
`timescale 1ns/100ps
module tb_top import msc_pkg::*; ();
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, faultEvent;
  logic awready, wready, bvalid, arready, rvalid, irq, lowPowerMode, initPending, inReset;
  logic [7:0] awaddr, araddr, settingByte;
  logic [31:0] wdata, rdata, stat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int numErrors, checked;
  //////////////////////////////////////////////////////////////////////////////
  // clock and the two ends; short counts keep reset scenarios brief
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  msc_if lnk();
  msc_device #(.RST_MIN_CYC(16'h000c), .INIT_CYC(24'h00000a)) u_msc_device (.clk, .rst_b,
    .link(lnk), .faultEvent, .lowPowerMode, .settingByte, .initPending, .inReset);
  msc_host u_msc_host (.clk, .rst_b, .link(lnk), .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq);
  msc_properties #(.RST_MIN_CYC(12)) u_msc_properties (.clk, .rst_b,
    .module_select_n(lnk.module_select_n), .module_reset_n(lnk.module_reset_n),
    .low_power_select(lnk.low_power_select), .sdaOeDev(lnk.sdaOeDev),
    .alertOeDev(lnk.alertOeDev), .module_present_n(lnk.module_present_n),
    .faultEvent, .lowPowerMode);
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // guarded releases avoid a second assignment when the next call starts
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid) begin
        chk("bresp", 32'h0, 32'(bresp));
        bready <= 1'h0;
      end
    end while ((awvalid || wvalid || bready) && n < 50);
    chk("write hang", 32'h0, 32'(bready));
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
    end while ((arvalid || rready) && n < 50);
    chk("read hang", 32'h0, 32'(rready));
  endtask
  // one 2-wire frame, then poll until the engine is idle
  task xfer(input logic [31:0] c);
    int n;
    n = 0;
    axw(OFS_CMD, c);
    stat = 32'h1;
    while (stat[STAT_BUSY] !== 1'h0 && n < 100) begin
      axr(OFS_STAT, stat, resp);
      n++;
    end
    chk("busy", 32'h0, 32'(stat[STAT_BUSY]));
  endtask
  task wait_alert(input logic lv);
    int n;
    n = 0;
    while (lnk.fault_alert_n !== lv && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("alert pin", 32'(lv), 32'(lnk.fault_alert_n));
  endtask
  task pulse_fault;
    faultEvent <= 1'h1;
    @(posedge clk);
    faultEvent <= 1'h0;
    wait_alert(1'h0);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'h0;
    {rst_b, awvalid, wvalid, bready, arvalid, rready, faultEvent} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    axw(OFS_IRQ_MASK, 32'h0);
    wait_alert(1'h0);
    chk("pending", 32'h0, 32'(initPending));
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    axw(OFS_IRQ_MASK, 32'h7);
    chk("irq", 32'h1, 32'(irq));
    axw(OFS_IRQ_STAT, 32'h7);
    chk("irq clear", 32'h0, 32'(irq));
    axw(OFS_CTRL, 32'h5);
    xfer(32'h3);
    chk("status", 32'h00030a00, stat & 32'h0003ff03);
    chk("alert free", 32'h1, 32'(lnk.fault_alert_n));
    xfer(32'ha501);
    chk("setting", 32'ha5, 32'(settingByte));
    axw(OFS_CTRL, 32'h4);
    xfer(32'h3c01);
    chk("nack", 32'h2, stat & 32'h3);
    chk("unselected", 32'ha5, 32'(settingByte));
    axw(OFS_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    chk("low power", 32'h0, 32'(lowPowerMode));
    pulse_fault();
    xfer(32'h3);
    chk("fault status", 32'h0400, stat & 32'hff03);
    axw(OFS_CTRL, 32'hd);
    pulse_fault();
    wait_alert(1'h1);
    axw(OFS_CTRL, 32'h5);
    pulse_fault();
    axw(OFS_CTRL, 32'h7);
    axw(OFS_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    chk("short alert", 32'h0, 32'(lnk.fault_alert_n));
    chk("short setting", 32'ha5, 32'(settingByte));
    axw(OFS_CTRL, 32'h7);
    repeat (30) @(posedge clk);
    chk("in reset", 32'h1, 32'(inReset));
    chk("pend held", 32'h1, 32'(initPending));
    chk("defaults", 32'h0, 32'(settingByte));
    axr(OFS_STAT, stat, resp);
    chk("untrusted", 32'h0, 32'(stat[STAT_TRUSTED]));
    axw(OFS_CTRL, 32'h5);
    wait_alert(1'h0);
    chk("pend clear", 32'h0, 32'(initPending));
    repeat (3) @(posedge clk);
    axr(OFS_STAT, stat, resp);
    chk("trusted", 32'h1, 32'(stat[STAT_TRUSTED]));
    axr(8'h14, stat, resp);
    chk("unmapped", 32'h2, {30'h0, resp});
    chk("unmapped data", 32'h0, stat);
    print_verdict();
  end
endmodule
